// ---- hdl/amrf_cfg.svh ----
`ifndef AMRF_CFG_SVH
`define AMRF_CFG_SVH

// Register offsets
`define AMRF_ADDR_RES_LO 8'h78
`define AMRF_ADDR_RES_HI 8'h79
`define AMRF_ADDR_SEL 8'h7c
`define AMRF_ADDR_IRQ_STAT 8'h70
`define AMRF_ADDR_IRQ_CLR 8'h71
`define AMRF_ADDR_IRQ_EN 8'h72
`define AMRF_ADDR_CONV_STAT 8'h73

// Selection register fields
`define AMRF_VREF_MSB 7
`define AMRF_VREF_LSB 6
`define AMRF_LEFT_BIT 5
`define AMRF_CHAN_MSB 4
`define AMRF_CHAN_LSB 0

// Event bits of the interrupt registers
`define AMRF_EVT_DONE 0
`define AMRF_EVT_OVERRUN 1
`define AMRF_EVT_REF_WARN 2
`define AMRF_EVT_W 3

// Reset values
`define AMRF_SEL_RST 8'h00
`define AMRF_EVT_RST 3'h0
`define AMRF_RES_RST 10'h000

// Result limits and special channel codes
`define AMRF_SE_MAX 10'h3ff
`define AMRF_DIFF_MAX 10'h1ff
`define AMRF_DIFF_MIN 10'h200
`define AMRF_CH_BANDGAP 5'h1e
`define AMRF_CH_GND 5'h1f

`endif

// ---- hdl/amrf_pkg.sv ----
package amrf_pkg;

    typedef enum logic [1:0] {
        VREF_EXT = 2'b00,
        VREF_SUPPLY = 2'b01,
        VREF_BG11 = 2'b10,
        VREF_INT256 = 2'b11
    } amrf_vref_t;

    typedef enum logic [1:0] {
        GAIN_1X = 2'b00,
        GAIN_10X = 2'b01,
        GAIN_200X = 2'b10
    } amrf_gain_t;

    typedef enum logic [1:0] {
        SRC_PIN = 2'b00,
        SRC_BANDGAP = 2'b01,
        SRC_GND = 2'b10
    } amrf_src_t;

    typedef enum logic {
        CONV_IDLE = 1'b0,
        CONV_BUSY = 1'b1
    } amrf_conv_state_t;

    typedef struct packed {
        amrf_vref_t vref_select;
        logic left_justify;
        logic [4:0] channel_gain_select;
    } amrf_sel_t;

    typedef struct packed {
        amrf_vref_t vref_select;
        amrf_src_t src;
        logic diff;
        amrf_gain_t gain;
        logic [2:0] pos_pin;
        logic [2:0] neg_pin;
    } amrf_route_t;

endpackage : amrf_pkg

// ---- hdl/amrf_route_decode.sv ----
`timescale 1ns/10ps
`include "amrf_cfg.svh"

module amrf_route_decode (
    // Selection in
    input wire amrf_pkg::amrf_sel_t sel,
    // Analog routing out
    output amrf_pkg::amrf_route_t route
);
    import amrf_pkg::*;

    logic [4:0] code;

    assign code = sel.channel_gain_select;

    always_comb begin
        route = '{vref_select: sel.vref_select, src: SRC_PIN, diff: 1'b0,
                  gain: GAIN_1X, pos_pin: code[2:0], neg_pin: 3'h0};
        case (code[4:3])
            2'b00: begin
                route.diff = 1'b0;
            end
            2'b01: begin
                // Pairs against pin 0 or pin 2 with 10x or 200x gain
                route.diff = 1'b1;
                route.pos_pin = {1'b0, code[2], code[0]};
                route.neg_pin = {1'b0, code[2], 1'b0};
                route.gain = code[1] ? GAIN_200X : GAIN_10X;
            end
            2'b10: begin
                route.diff = 1'b1;
                route.neg_pin = 3'h1;
            end
            default: begin
                if (code == `AMRF_CH_BANDGAP) begin
                    route.src = SRC_BANDGAP;
                end else if (code == `AMRF_CH_GND) begin
                    route.src = SRC_GND;
                end else begin
                    route.diff = 1'b1;
                    route.neg_pin = 3'h2;
                end
            end
        endcase
    end

endmodule : amrf_route_decode

// ---- hdl/amrf_result_sat.sv ----
`timescale 1ns/10ps
`include "amrf_cfg.svh"

module amrf_result_sat (
    // Core count and mode
    input wire logic signed [12:0] raw,
    input wire logic diff,
    // Stored result code
    output logic [9:0] code
);
    import amrf_pkg::*;

    always_comb begin
        if (diff) begin
            // Two's complement, clamped to -512..+511
            if (raw > 13'sd511) begin
                code = `AMRF_DIFF_MAX;
            end else if (raw < -13'sd512) begin
                code = `AMRF_DIFF_MIN;
            end else begin
                code = raw[9:0];
            end
        end else begin
            // Unsigned, clamped to 0..1023
            if (raw < 13'sd0) begin
                code = 10'h000;
            end else if (raw > 13'sd1023) begin
                code = `AMRF_SE_MAX;
            end else begin
                code = raw[9:0];
            end
        end
    end

endmodule : amrf_result_sat

// ---- hdl/amrf_top.sv ----
// How it works
// - Done result readable in low/high registers
// - Single-ended: unsigned 10-bit code, clamped
// - Differential: two's complement, saturating at limits
// - Differential scale is difference*gain*512/reference
// - Differential top result bit is sign
// - Left-justify bit 5 selects result alignment
// - Alignment change shows at once
// - Bits 7:6 choose the reference source
// - Selection writes wait for conversion end
// - Codes 0-7 pins, 1e bandgap, 1f ground
// - Differential pair and gain code decoding
// - Done flag raised in the same cycle as the result update
// - Low read locks results until high read
//
// Implementation choice: strobed register access.
`timescale 1ns/10ps
`include "amrf_cfg.svh"

module amrf_top (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rd_data,
    // Converter core
    input wire logic conv_start,
    input wire logic conv_end,
    input wire logic signed [12:0] conv_raw,
    output amrf_pkg::amrf_route_t core_route,
    output logic conv_busy,
    // Interrupt
    output logic irq
);
    import amrf_pkg::*;

    amrf_sel_t sel_reg;
    amrf_sel_t sel_next;
    amrf_route_t route_next;
    amrf_route_t core_route_reg;
    amrf_conv_state_t state_reg;
    amrf_conv_state_t state_next;
    logic [9:0] result_reg;
    logic [9:0] sat_code;
    logic lock_reg;
    logic [`AMRF_EVT_W-1:0] evt_status_reg;
    logic [`AMRF_EVT_W-1:0] evt_enable_reg;
    logic [`AMRF_EVT_W-1:0] evt_set;
    logic [`AMRF_EVT_W-1:0] evt_clr;
    logic [7:0] rd_data_reg;
    logic [7:0] rd_next;
    logic irq_reg;
    logic wr_sel;
    logic rd_lo;
    logic rd_hi;
    logic finish;
    logic accept;
    logic [7:0] res_lo_view;
    logic [7:0] res_hi_view;

    assign wr_sel = wr_en && (addr == `AMRF_ADDR_SEL);
    assign rd_lo = rd_en && (addr == `AMRF_ADDR_RES_LO);
    assign rd_hi = rd_en && (addr == `AMRF_ADDR_RES_HI);
    assign finish = (state_reg == CONV_BUSY) && conv_end;
    // A high read in the same cycle releases the lock before the update
    assign accept = finish && (!lock_reg || rd_hi);

    amrf_route_decode u_decode (
        .sel(sel_reg),
        .route(route_next)
    );

    amrf_result_sat u_sat (
        .raw(conv_raw),
        .diff(core_route_reg.diff),
        .code(sat_code)
    );

    // Selection register
    always_comb begin
        sel_next = sel_reg;
        if (wr_sel) begin
            sel_next.vref_select = amrf_vref_t'(wr_data[`AMRF_VREF_MSB:`AMRF_VREF_LSB]);
            sel_next.left_justify = wr_data[`AMRF_LEFT_BIT];
            sel_next.channel_gain_select = wr_data[`AMRF_CHAN_MSB:`AMRF_CHAN_LSB];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sel_reg <= amrf_sel_t'(`AMRF_SEL_RST);
        end else if (ce) begin
            sel_reg <= sel_next;
        end
    end

    // Conversion tracking
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            CONV_IDLE: begin
                if (conv_start) begin
                    state_next = CONV_BUSY;
                end
            end
            CONV_BUSY: begin
                if (conv_end) begin
                    state_next = CONV_IDLE;
                end
            end
            default: begin
                state_next = CONV_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= CONV_IDLE;
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    // Working copy of the routing, frozen while a conversion runs
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            core_route_reg <= '0;
        end else if (ce && state_reg == CONV_IDLE && conv_start) begin
            core_route_reg <= route_next;
        end
    end

    // Result storage with read lock
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            result_reg <= `AMRF_RES_RST;
        end else if (ce && accept) begin
            result_reg <= sat_code;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lock_reg <= 1'b0;
        end else if (ce) begin
            if (rd_hi) begin
                lock_reg <= 1'b0;
            end else if (rd_lo) begin
                lock_reg <= 1'b1;
            end
        end
    end

    // Events: done, result dropped under lock, gain code with supply or 1.1 V reference
    assign evt_set[`AMRF_EVT_DONE] = accept;
    assign evt_set[`AMRF_EVT_OVERRUN] = finish && !accept;
    assign evt_set[`AMRF_EVT_REF_WARN] = ce && state_reg == CONV_IDLE && conv_start &&
        route_next.diff && route_next.gain != GAIN_1X &&
        route_next.vref_select != VREF_INT256 && route_next.vref_select != VREF_EXT;
    assign evt_clr = (wr_en && addr == `AMRF_ADDR_IRQ_CLR) ?
        wr_data[`AMRF_EVT_W-1:0] : `AMRF_EVT_RST;

    genvar gi;
    generate
        for (gi = 0; gi < `AMRF_EVT_W; gi = gi + 1) begin : g_evt
            // Set wins over a clear in the same cycle
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    evt_status_reg[gi] <= 1'b0;
                end else if (ce) begin
                    if (evt_set[gi]) begin
                        evt_status_reg[gi] <= 1'b1;
                    end else if (evt_clr[gi]) begin
                        evt_status_reg[gi] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            evt_enable_reg <= `AMRF_EVT_RST;
        end else if (ce && wr_en && addr == `AMRF_ADDR_IRQ_EN) begin
            evt_enable_reg <= wr_data[`AMRF_EVT_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_reg <= 1'b0;
        end else if (ce) begin
            irq_reg <= |((evt_status_reg | evt_set) & evt_enable_reg);
        end
    end

    // Result views follow the live justify bit
    always_comb begin
        if (sel_reg.left_justify) begin
            res_hi_view = result_reg[9:2];
            res_lo_view = {result_reg[1:0], 6'h00};
        end else begin
            res_hi_view = {6'h00, result_reg[9:8]};
            res_lo_view = result_reg[7:0];
        end
    end

    always_comb begin
        rd_next = 8'h00;
        if (rd_en) begin
            case (addr)
                `AMRF_ADDR_SEL: rd_next = sel_reg;
                `AMRF_ADDR_RES_LO: rd_next = res_lo_view;
                `AMRF_ADDR_RES_HI: rd_next = res_hi_view;
                `AMRF_ADDR_IRQ_STAT: rd_next = {5'h00, evt_status_reg};
                `AMRF_ADDR_IRQ_EN: rd_next = {5'h00, evt_enable_reg};
                `AMRF_ADDR_CONV_STAT: rd_next = {5'h00, core_route_reg.diff, lock_reg,
                    state_reg == CONV_BUSY};
                default: rd_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_data_reg <= 8'h00;
        end else if (ce) begin
            rd_data_reg <= rd_next;
        end
    end

    assign rd_data = rd_data_reg;
    assign irq = irq_reg;
    assign core_route = core_route_reg;
    assign conv_busy = (state_reg == CONV_BUSY);

    // Checks
    property p_done_flag;
        @(posedge clk) disable iff (sys_rst)
        ce && accept |=> evt_status_reg[`AMRF_EVT_DONE] && result_reg == $past(sat_code);
    endproperty
    a_done_flag: assert property (p_done_flag) else $error("done without result");

    property p_result_read;
        @(posedge clk) disable iff (sys_rst)
        ce && rd_lo && !sel_reg.left_justify |=> rd_data == $past(result_reg[7:0]) ##1
            ($past(rd_en) || !$past(ce) || rd_data == 8'h00);
    endproperty
    a_result_read: assert property (p_result_read) else $error("low read wrong");

    property p_se_clamp;
        @(posedge clk) disable iff (sys_rst)
        ce && accept && !core_route_reg.diff && conv_raw > 13'sd1023 |=> result_reg == 10'h3ff;
    endproperty
    a_se_clamp: assert property (p_se_clamp) else $error("single clamp wrong");

    property p_diff_clamp;
        @(posedge clk) disable iff (sys_rst)
        ce && accept && core_route_reg.diff && conv_raw < -13'sd512 |=> result_reg == 10'h200;
    endproperty
    a_diff_clamp: assert property (p_diff_clamp) else $error("diff clamp wrong");

    property p_diff_scale;
        @(posedge clk) disable iff (sys_rst)
        ce && accept && core_route_reg.diff && conv_raw == -13'sd400 |=> result_reg == 10'h270;
    endproperty
    a_diff_scale: assert property (p_diff_scale) else $error("diff code wrong");

    property p_sign;
        @(posedge clk) disable iff (sys_rst)
        ce && accept && core_route_reg.diff |=> result_reg[9] == $past(conv_raw[12]);
    endproperty
    a_sign: assert property (p_sign) else $error("sign bit wrong");

    property p_left;
        @(posedge clk) disable iff (sys_rst)
        ce && rd_hi && sel_reg.left_justify && !accept |=> rd_data == $past(result_reg[9:2]);
    endproperty
    a_left: assert property (p_left) else $error("left view wrong");

    property p_justify_now;
        @(posedge clk) disable iff (sys_rst)
        ce && wr_sel && !wr_data[`AMRF_LEFT_BIT] |=> !sel_reg.left_justify;
    endproperty
    a_justify_now: assert property (p_justify_now) else $error("justify late");

    property p_vref;
        @(posedge clk) disable iff (sys_rst)
        ce && state_reg == CONV_IDLE && conv_start |=>
            core_route.vref_select == $past(sel_reg.vref_select);
    endproperty
    a_vref: assert property (p_vref) else $error("reference not taken");

    property p_hold;
        @(posedge clk) disable iff (sys_rst)
        state_reg == CONV_BUSY && !conv_end |=> $stable(core_route_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("route moved mid conversion");

    property p_gnd;
        @(posedge clk) disable iff (sys_rst)
        ce && !conv_busy && conv_start && sel_reg.channel_gain_select == 5'h1f |=>
            core_route.src == SRC_GND && !core_route.diff;
    endproperty
    a_gnd: assert property (p_gnd) else $error("ground code wrong");

    property p_gain;
        @(posedge clk) disable iff (sys_rst)
        ce && !conv_busy && conv_start && sel_reg.channel_gain_select == 5'h0f |=>
            core_route.gain == GAIN_200X && core_route.pos_pin == 3'h3 &&
            core_route.neg_pin == 3'h2;
    endproperty
    a_gain: assert property (p_gain) else $error("gain pair wrong");

    property p_lock;
        @(posedge clk) disable iff (sys_rst)
        lock_reg && !rd_hi |=> $stable(result_reg);
    endproperty
    a_lock: assert property (p_lock) else $error("result changed under lock");

    property p_reset;
        @(posedge clk) sys_rst |=> sel_reg == 8'h00 && rd_data == 8'h00 && !irq;
    endproperty
    a_reset: assert property (p_reset) else $error("reset value wrong");

    property p_capture;
        @(posedge clk) disable iff (sys_rst)
        ce && !conv_busy && conv_start |=> core_route == $past(route_next);
    endproperty
    a_capture: assert property (p_capture) else $error("working copy missed");

    c_done: cover property (@(posedge clk) disable iff (sys_rst) ce && accept);
    c_overrun: cover property (@(posedge clk) disable iff (sys_rst) ce && finish && !accept);
    c_diff: cover property (@(posedge clk) disable iff (sys_rst) accept && core_route_reg.diff);
    c_irq: cover property (@(posedge clk) disable iff (sys_rst) $rose(irq));

endmodule : amrf_top

// ---- verif/amrf_core_model.sv ----
`timescale 1ns/10ps

module amrf_core_model (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Bench command
    input wire logic go,
    input wire logic [3:0] wait_cycles,
    input wire logic signed [12:0] raw_value,
    // Core link
    output logic conv_start,
    output logic conv_end,
    output logic signed [12:0] conv_raw,
    output logic running
);
    logic [3:0] cnt_reg;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            conv_start <= 1'b0;
            conv_end <= 1'b0;
            running <= 1'b0;
            cnt_reg <= 4'h0;
            conv_raw <= 13'h0aaa;
        end else begin
            conv_start <= 1'b0;
            conv_end <= 1'b0;
            // Count is only meaningful beside the end pulse, so it churns otherwise
            conv_raw <= ~conv_raw;
            if (go && !running) begin
                conv_start <= 1'b1;
                running <= 1'b1;
                cnt_reg <= wait_cycles;
            end else if (running) begin
                if (cnt_reg == 4'h0) begin
                    // Count follows difference*gain*512/reference, given by the bench
                    conv_end <= 1'b1;
                    conv_raw <= raw_value;
                    running <= 1'b0;
                end else begin
                    cnt_reg <= cnt_reg - 4'h1;
                end
            end
        end
    end
endmodule : amrf_core_model

// ---- verif/tb_top.sv ----
`timescale 1ns/10ps

module tb_top;
    import amrf_pkg::*;
    logic clk, sys_rst, ce, wr_en, rd_en, go, conv_start, conv_end, conv_busy, irq, running;
    logic [7:0] addr, wr_data, rd_data, d;
    logic [3:0] wait_cycles;
    logic signed [12:0] raw_value, conv_raw, r;
    amrf_route_t core_route;
    integer seed = 32;
    integer n_mismatch = 0;
    integer comparisons = 0;
    integer cycles = 0;
    integer i;
    logic [1:0] v;
    logic lj;

    amrf_top uut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .conv_start(conv_start),
        .conv_end(conv_end), .conv_raw(conv_raw), .core_route(core_route),
        .conv_busy(conv_busy), .irq(irq));
    amrf_core_model core (.clk(clk), .sys_rst(sys_rst), .go(go), .wait_cycles(wait_cycles),
        .raw_value(raw_value), .conv_start(conv_start), .conv_end(conv_end),
        .conv_raw(conv_raw), .running(running));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic report_and_stop;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] dat);
        @(posedge clk);
        addr <= a;
        wr_data <= dat;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] dat);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 dat = rd_data;
    endtask : rd

    task automatic start_conv(input logic signed [12:0] raw, input logic [3:0] w);
        @(posedge clk);
        go <= 1'b1;
        raw_value <= raw;
        wait_cycles <= w;
        @(posedge clk);
        go <= 1'b0;
    endtask : start_conv

    task automatic finish_conv;
        for (int k = 0; k < 40; k++) begin
            @(posedge clk);
            #1;
            if (!running) break;
        end
        @(posedge clk);
        #1;
    endtask : finish_conv

    task automatic run_conv(input logic signed [12:0] raw, input logic [3:0] w);
        start_conv(raw, w);
        finish_conv();
    endtask : run_conv

    function automatic logic [9:0] exp_code(input logic signed [12:0] raw, input logic df);
        if (df) begin
            if (raw > 511) return 10'h1ff;
            if (raw < -512) return 10'h200;
            return raw[9:0];
        end
        if (raw > 1023) return 10'h3ff;
        if (raw < 0) return 10'h000;
        return raw[9:0];
    endfunction : exp_code

    task automatic read_result(input logic [9:0] c, input logic left);
        logic [7:0] lo, hi;
        rd(8'h78, lo);
        rd(8'h79, hi);
        chk("res_lo", lo, left ? {c[1:0], 6'h00} : c[7:0]);
        chk("res_hi", hi, left ? c[9:2] : {6'h00, c[9:8]});
    endtask : read_result

    task automatic check_route(input logic [1:0] vr, input logic [4:0] c);
        logic df;
        amrf_src_t s;
        logic [7:0] pe;
        df = (c >= 5'h08) && (c <= 5'h1d);
        s = c == 5'h1e ? SRC_BANDGAP : c == 5'h1f ? SRC_GND : SRC_PIN;
        pe = {GAIN_1X, c[2:0], c[3] ? 3'h2 : 3'h1};
        if (c[4:3] == 2'b01) begin
            pe = {c[1] ? GAIN_200X : GAIN_10X, 1'b0, c[2], c[0], 1'b0, c[2], 1'b0};
        end
        chk("vref", core_route.vref_select, vr);
        chk("src", core_route.src, s);
        chk("diff", core_route.diff, df);
        if (c < 5'h08) chk("pin", core_route.pos_pin, c[2:0]);
        if (df) chk("pair", {core_route.gain, core_route.pos_pin, core_route.neg_pin}, pe);
    endtask : check_route

    initial begin
        sys_rst = 1'b1;
        ce = 1'b1;
        addr = 8'h00;
        wr_data = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        go = 1'b0;
        wait_cycles = 4'h0;
        raw_value = 13'h0000;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        rd(8'h7c, d);
        chk("sel_reset", d, 8'h00);
        chk("route_reset", core_route, 13'h0000);
        rd(8'h40, d);
        chk("unmapped", d, 8'h00);
        // Worked example: pair 3-2 at 10x, 2.56 V, left adjusted
        wr(8'h7c, 8'hed);
        run_conv(13'(512 * 10 * (300 - 500) / 2560), 4'h2);
        check_route(2'b11, 5'h0d);
        read_result(10'h270, 1'b1);
        wr(8'h7c, 8'hcd);
        read_result(10'h270, 1'b0);
        rd(8'h70, d);
        chk("ref_ok", d[2], 1'b0);
        wr(8'h71, 8'h07);
        // Every channel code with random reference, layout and count
        for (i = 0; i < 32; i++) begin
            v = 2'($random(seed));
            lj = 1'($random(seed));
            r = 13'($random(seed) % 1400);
            wr(8'h7c, {v, lj, 5'(i)});
            run_conv(r, 4'($random(seed) & 3));
            check_route(v, 5'(i));
            read_result(exp_code(r, (i >= 8) && (i <= 29)), lj);
            rd(8'h70, d);
            chk("done_flag", d[0], 1'b1);
            chk("ref_warn", d[2], (i >= 8) && (i <= 15) && (v == 2'b01 || v == 2'b10));
            wr(8'h71, 8'h07);
        end
        // Selection written mid-conversion waits; layout changes at once
        wr(8'h7c, 8'h43);
        run_conv(13'd100, 4'h0);
        start_conv(-13'sd200, 4'hf);
        wr(8'h7c, 8'hf8);
        chk("busy", conv_busy, 1'b1);
        check_route(2'b01, 5'h03);
        read_result(10'h064, 1'b1);
        finish_conv();
        read_result(10'h000, 1'b1);
        run_conv(13'd300, 4'h1);
        check_route(2'b11, 5'h18);
        read_result(10'h12c, 1'b1);
        // Low read locks the result until the high read
        rd(8'h78, d);
        chk("lock_lo", d, 8'h00);
        run_conv(-13'sd5, 4'h0);
        rd(8'h79, d);
        chk("lock_hi", d, 8'h4b);
        rd(8'h70, d);
        chk("overrun", d[1], 1'b1);
        wr(8'h71, 8'h07);
        run_conv(-13'sd5, 4'h0);
        read_result(10'h3fb, 1'b1);
        // Saturation corners, single-ended then differential 1x
        wr(8'h7c, 8'h02);
        run_conv(13'sd1500, 4'h0);
        read_result(10'h3ff, 1'b0);
        run_conv(-13'sd9, 4'h1);
        read_result(10'h000, 1'b0);
        wr(8'h7c, 8'hd0);
        run_conv(-13'sd900, 4'h0);
        read_result(10'h200, 1'b0);
        run_conv(13'sd700, 4'h0);
        read_result(10'h1ff, 1'b0);
        // Interrupt raised, cleared and masked
        wr(8'h71, 8'h07);
        wr(8'h72, 8'h01);
        run_conv(13'd10, 4'h0);
        chk("irq_on", irq, 1'b1);
        wr(8'h71, 8'h01);
        @(posedge clk);
        #1 chk("irq_clr", irq, 1'b0);
        wr(8'h72, 8'h00);
        run_conv(13'd10, 4'h0);
        chk("irq_mask", irq, 1'b0);
        rd(8'h70, d);
        chk("done_masked", d[0], 1'b1);
        rd(8'h72, d);
        chk("enable_rb", d, 8'h00);
        // Enable low freezes the selection; a mid-run reset clears it
        @(posedge clk);
        ce <= 1'b0;
        wr(8'h7c, 8'h00);
        ce <= 1'b1;
        rd(8'h7c, d);
        chk("ce_hold", d, 8'hd0);
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        rd(8'h7c, d);
        chk("sel_rerst", d, 8'h00);
        chk("route_rerst", core_route, 13'h0000);
        report_and_stop();
    end
endmodule : tb_top
